/* tap_engine_pkg.sv */
/*
  Constants for the tap detection engine: register offsets, field
  positions, command codes and parameter reset values.
  Assumes the register port of the host serial interface uses 8-bit
  addresses and 8-bit data.
*/
package tap_engine_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_PARAM_BYTE_0 = 8'h0b;
  localparam logic [7:0] ADDR_PARAM_BYTE_1 = 8'h0c;
  localparam logic [7:0] ADDR_PARAM_BYTE_2 = 8'h0d;
  localparam logic [7:0] ADDR_PARAM_BYTE_3 = 8'h0e;
  localparam logic [7:0] ADDR_PARAM_BYTE_4 = 8'h0f;
  localparam logic [7:0] ADDR_PARAM_BYTE_5 = 8'h10;
  localparam logic [7:0] ADDR_PARAM_BYTE_6 = 8'h11;
  localparam logic [7:0] ADDR_PARAM_SET_SELECT = 8'h12;
  localparam logic [7:0] ADDR_ACCEL_CONFIG = 8'h03;
  localparam logic [7:0] ADDR_SENSOR_ENABLE = 8'h08;
  localparam logic [7:0] ADDR_ENGINE_CONTROL = 8'h09;
  localparam logic [7:0] ADDR_COMMAND = 8'h0a;
  localparam logic [7:0] ADDR_INTERRUPT_STATUS = 8'h2d;
  localparam logic [7:0] ADDR_EVENT_STATUS = 8'h2f;
  localparam logic [7:0] ADDR_TAP_RESULT = 8'h59;

  // ----------------------------------------------------------------
  // Fields, codes and reset values
  // ----------------------------------------------------------------
  localparam int BIT_TAP_ENABLE = 0;
  localparam int BIT_ROUTE_LINE_A = 6;
  localparam int BIT_ACCEL_ON = 0;
  localparam int BIT_TAP_EVENT = 1;
  localparam int LSB_RATE = 0;
  localparam int MSB_RATE = 3;
  localparam int LSB_COUNT = 0;
  localparam int LSB_AXIS = 4;
  localparam int BIT_SIGN = 7;
  localparam logic [7:0] CMD_CONFIGURE_TAP = 8'h0c;
  localparam logic [7:0] SET_FIRST = 8'h01;
  localparam logic [7:0] SET_SECOND = 8'h02;
  localparam logic [1:0] COUNT_SINGLE = 2'h1;
  localparam logic [1:0] COUNT_DOUBLE = 2'h2;
  localparam logic [1:0] AXIS_X = 2'h1;
  localparam logic [1:0] AXIS_Y = 2'h2;
  localparam logic [1:0] AXIS_Z = 2'h3;
  localparam int WEIGHT_FRAC = 7;
  localparam int THRESH_FRAC = 10;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [15:0] WORD_RESET = 16'h0000;

endpackage

/* tap_detection_engine.sv */
/*
  Tap detection engine: parameter staging, engine control, single and
  double tap detection on accelerometer samples, result and status
  registers, and routing of the tap event to two interrupt lines.
  Assumes samples arrive from logic on ref_clk, one sample_valid pulse
  per sample in g with 10 fractional bits, and a register port already
  decoded by the host serial interface.
*/
// Operation
// - Double tap timeout is a 16-bit sample count from first peak.
// - Acceleration average weight is unsigned 8 bits, 7 fraction bits.
// - Movement magnitude weight is unsigned 8 bits, 7 fraction bits.
// - Peak threshold is unsigned 16 bits, 10 fraction bits, g squared.
// - Quiet threshold is unsigned 16 bits, 10 fraction bits, linear g.
// - Axis tie order codes 0 to 5 map orders; 6 and 7 act as 0.
// - Set select 0x01 loads peak limit, tie order, quiet time, timeout.
// - Set select 0x02 loads both weights and both thresholds.
// - Only low three bits of the tie order byte are used.
// - Command 0x0C transfers the staged set into the engine.
// - Detection runs when control bit 0 and accelerometer are on and the rate code is nonzero.
// - Detection stops when control bit 0 or accelerometer is off.
// - Control bit 6 routes event to line A when one, else B.
// - Tap interrupt appears one cycle after the sample ready strobe.
// - A reported tap sets bit 1 of the event status register.
// - Tap result register updates when a tap event is detected.
// - Tap count reads 1 for single and 2 for double tap.
// - Axis of first valid peak coded 1 X, 2 Y, 3 Z, ties by order.
// - Tap sign comes from linear acceleration sign at first peak.
// - Linear acceleration is sample minus average; square sum starts peak.
// - Peak valid only if movement average is quiet at peak end.
// - Second tap inside post-tap quiet time restarts without event.
// - No second tap before timeout reports single; later tap restarts.
`timescale 1ns/10ps
`default_nettype none

module tap_detection_engine
  import tap_engine_pkg::*;
#(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic                ref_clk,
  input  wire logic                resetn,
  // Register port
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  input  wire logic [7:0]          reg_addr,
  input  wire logic [7:0]          reg_wdata,
  output logic      [7:0]          reg_rdata,
  // Accelerometer samples
  input  wire logic                sample_valid,
  input  wire logic signed [W-1:0] accel_x,
  input  wire logic signed [W-1:0] accel_y,
  input  wire logic signed [W-1:0] accel_z,
  input  wire logic                sample_ready,
  // Interrupt lines
  output logic                     interrupt_line_a,
  output logic                     interrupt_line_b
);

  // ----------------------------------------------------------------
  // Types and helpers
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_PEAK1, ST_QUIET, ST_WAIT2, ST_PEAK2
  } state_type;

  localparam int LW = W + 1;
  localparam int SW = 2 * LW + 2;

  // Running average step; weight has 7 fraction bits
  function automatic logic signed [LW:0] ewma(
    input logic signed [LW:0] avg,
    input logic signed [LW:0] smp,
    input logic        [7:0]  wgt
  );
    logic signed [LW+10:0] prod;
    prod = (smp - avg) * $signed({1'b0, wgt});
    ewma = avg + (LW+1)'(prod >>> WEIGHT_FRAC);
  endfunction

  function automatic logic [LW-1:0] mag(input logic signed [LW-1:0] v);
    mag = v[LW-1] ? LW'(-v) : v;
  endfunction

  // Pick the largest axis; ties go to the first in the order code
  function automatic logic [1:0] pick_axis(
    input logic [LW-1:0] ax,
    input logic [LW-1:0] ay,
    input logic [LW-1:0] az,
    input logic [2:0]    ord
  );
    logic [LW-1:0] top;
    logic [5:0]    seq;
    logic [1:0]    cand;
    top = (ax >= ay) ? ax : ay;
    top = (top >= az) ? top : az;
    case (ord)
      3'h1:    seq = {AXIS_X, AXIS_Z, AXIS_Y};
      3'h2:    seq = {AXIS_Y, AXIS_X, AXIS_Z};
      3'h3:    seq = {AXIS_Y, AXIS_Z, AXIS_X};
      3'h4:    seq = {AXIS_Z, AXIS_X, AXIS_Y};
      3'h5:    seq = {AXIS_Z, AXIS_Y, AXIS_X};
      default: seq = {AXIS_X, AXIS_Y, AXIS_Z};
    endcase
    pick_axis = AXIS_X;
    for (int i = 2; i >= 0; i--) begin
      cand = seq[2*i +: 2];
      if ((cand == AXIS_X && ax == top) || (cand == AXIS_Y && ay == top) ||
          (cand == AXIS_Z && az == top)) begin
        pick_axis = cand;
        break;
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [7:0]  stage_q [7];
  logic [7:0]  set_select_q;
  logic [7:0]  accel_config_q;
  logic [7:0]  sensor_enable_q;
  logic [7:0]  engine_control_q;
  logic [7:0]  peak_limit_q;
  logic [2:0]  tie_order_q;
  logic [15:0] quiet_time_q;
  logic [15:0] dtap_timeout_q;
  logic [7:0]  alpha_q;
  logic [7:0]  gamma_q;
  logic [15:0] peak_thr_q;
  logic [15:0] quiet_thr_q;
  logic [7:0]  tap_result_q;
  logic        event_flag_q;
  logic        int_flag_q;
  logic        pending_q;

  wire         report;
  wire  [7:0]  result_new;
  wire         cmd_load = reg_wr && reg_addr == ADDR_COMMAND &&
                          reg_wdata == CMD_CONFIGURE_TAP;
  wire         stage_hit = reg_addr >= ADDR_PARAM_BYTE_0 &&
                           reg_addr <= ADDR_PARAM_BYTE_6;
  wire  [2:0]  stage_idx = 3'(reg_addr - ADDR_PARAM_BYTE_0);
  wire         rd_event = reg_rd && reg_addr == ADDR_EVENT_STATUS;
  wire         rd_int = reg_rd && reg_addr == ADDR_INTERRUPT_STATUS;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 7; i++) stage_q[i] <= REG_RESET;
      set_select_q     <= REG_RESET;
      accel_config_q   <= REG_RESET;
      sensor_enable_q  <= REG_RESET;
      engine_control_q <= REG_RESET;
    end else if (reg_wr) begin
      if (stage_hit) stage_q[stage_idx] <= reg_wdata;
      case (reg_addr)
        ADDR_PARAM_SET_SELECT: set_select_q     <= reg_wdata;
        ADDR_ACCEL_CONFIG:     accel_config_q   <= reg_wdata;
        ADDR_SENSOR_ENABLE:    sensor_enable_q  <= reg_wdata;
        ADDR_ENGINE_CONTROL:   engine_control_q <= reg_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      peak_limit_q   <= REG_RESET;
      tie_order_q    <= 3'h0;
      quiet_time_q   <= WORD_RESET;
      dtap_timeout_q <= WORD_RESET;
      alpha_q        <= REG_RESET;
      gamma_q        <= REG_RESET;
      peak_thr_q     <= WORD_RESET;
      quiet_thr_q    <= WORD_RESET;
    end else if (cmd_load && set_select_q == SET_FIRST) begin
      peak_limit_q   <= stage_q[0];
      tie_order_q    <= stage_q[1][2:0];
      quiet_time_q   <= {stage_q[3], stage_q[2]};
      dtap_timeout_q <= {stage_q[5], stage_q[4]};
    end else if (cmd_load && set_select_q == SET_SECOND) begin
      alpha_q     <= stage_q[0];
      gamma_q     <= stage_q[1];
      peak_thr_q  <= {stage_q[3], stage_q[2]};
      quiet_thr_q <= {stage_q[5], stage_q[4]};
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      event_flag_q <= 1'b0;
      int_flag_q   <= 1'b0;
      tap_result_q <= REG_RESET;
    end else begin
      event_flag_q <= report | (event_flag_q & ~rd_event);
      int_flag_q   <= report | (int_flag_q & ~rd_int);
      if (report) tap_result_q <= result_new;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= REG_RESET;
    end else if (reg_rd) begin
      case (reg_addr)
        ADDR_PARAM_SET_SELECT: reg_rdata <= set_select_q;
        ADDR_ACCEL_CONFIG:     reg_rdata <= accel_config_q;
        ADDR_SENSOR_ENABLE:    reg_rdata <= sensor_enable_q;
        ADDR_ENGINE_CONTROL:   reg_rdata <= engine_control_q;
        ADDR_TAP_RESULT:       reg_rdata <= tap_result_q;
        ADDR_EVENT_STATUS:     reg_rdata <= 8'(event_flag_q) << BIT_TAP_EVENT;
        ADDR_INTERRUPT_STATUS: reg_rdata <= 8'(int_flag_q) << BIT_TAP_EVENT;
        default: reg_rdata <= stage_hit ? stage_q[stage_idx] : REG_RESET;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Signal path
  // ----------------------------------------------------------------
  // start condition
  wire run = engine_control_q[BIT_TAP_ENABLE] &&
             sensor_enable_q[BIT_ACCEL_ON] &&
             accel_config_q[MSB_RATE:LSB_RATE] != 4'h0;
  wire step = run && sample_valid;

  logic signed [LW:0]   avg_q [3];
  logic signed [LW:0]   move_q;
  logic signed [LW-1:0] lin [3];
  logic        [LW-1:0] lmag [3];
  logic signed [W-1:0]  smp [3];
  logic        [SW-1:0] sq_sum;

  assign smp[0] = accel_x;
  assign smp[1] = accel_y;
  assign smp[2] = accel_z;

  always_comb begin
    sq_sum = '0;
    for (int i = 0; i < 3; i++) begin
      lin[i]  = LW'(smp[i]) - LW'(avg_q[i]);
      lmag[i] = mag(lin[i]);
      sq_sum  = sq_sum + SW'(lmag[i]) * SW'(lmag[i]);
    end
  end

  wire [LW-1:0] move_in = (lmag[0] >= lmag[1]) ?
                          ((lmag[0] >= lmag[2]) ? lmag[0] : lmag[2]) :
                          ((lmag[1] >= lmag[2]) ? lmag[1] : lmag[2]);
  // g squared threshold, 10 fraction bits
  wire over_peak = (sq_sum >> THRESH_FRAC) > SW'(peak_thr_q);
  wire quiet = move_q < (LW+1)'(quiet_thr_q);
  wire [1:0] axis_now = pick_axis(lmag[0], lmag[1], lmag[2], tie_order_q);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 3; i++) avg_q[i] <= '0;
      move_q <= '0;
    end else if (step) begin
      for (int i = 0; i < 3; i++)
        avg_q[i] <= ewma(avg_q[i], (LW+1)'(smp[i]), alpha_q);
      move_q <= ewma(move_q, (LW+1)'(move_in), gamma_q);
    end
  end

  // ----------------------------------------------------------------
  // Tap sequence
  // ----------------------------------------------------------------
  state_type   state_q;
  logic [7:0]  peak_cnt_q;
  logic [15:0] quiet_cnt_q;
  logic [15:0] dtap_cnt_q;
  logic [1:0]  axis_q;
  logic        sign_q;
  logic        report_q;
  logic [1:0]  count_q;

  wire peak_end = peak_cnt_q >= peak_limit_q;
  // timeout in samples from first peak
  wire dtap_over = dtap_cnt_q >= dtap_timeout_q;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
      peak_cnt_q <= REG_RESET;
      quiet_cnt_q <= WORD_RESET;
      dtap_cnt_q <= WORD_RESET;
      axis_q <= AXIS_X;
      sign_q <= 1'b0;
      report_q <= 1'b0;
      count_q <= COUNT_SINGLE;
    end else if (!run) begin
      state_q <= ST_IDLE;
      report_q <= 1'b0;
    end else begin
      report_q <= 1'b0;
      if (step) begin
        peak_cnt_q <= peak_cnt_q + 8'h01;
        quiet_cnt_q <= quiet_cnt_q + 16'h0001;
        if (dtap_cnt_q != 16'hffff) dtap_cnt_q <= dtap_cnt_q + 16'h0001;
        case (state_q)
          ST_IDLE: begin
            if (over_peak) begin
              state_q <= ST_PEAK1;
              peak_cnt_q <= REG_RESET;
              dtap_cnt_q <= WORD_RESET;
              axis_q <= axis_now;
              sign_q <= lin[axis_now - 2'h1][LW-1];
            end
          end
          ST_PEAK1: begin
            if (peak_end) begin
              state_q <= quiet ? ST_QUIET : ST_IDLE;
              quiet_cnt_q <= WORD_RESET;
            end
          end
          ST_QUIET: begin
            if (over_peak || !quiet) begin
              state_q <= ST_IDLE;
            end else if (quiet_cnt_q >= quiet_time_q) begin
              state_q <= ST_WAIT2;
            end
          end
          ST_WAIT2: begin
            if (dtap_over) begin
              state_q <= ST_IDLE;
              report_q <= 1'b1;
              count_q <= COUNT_SINGLE;
            end else if (over_peak) begin
              state_q <= ST_PEAK2;
              peak_cnt_q <= REG_RESET;
            end
          end
          ST_PEAK2: begin
            if (peak_end) begin
              state_q <= ST_IDLE;
              report_q <= 1'b1;
              count_q <= quiet ? COUNT_DOUBLE : COUNT_SINGLE;
            end
          end
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end

  assign report = report_q;
  assign result_new = (8'(count_q) << LSB_COUNT) |
                      (8'(axis_q) << LSB_AXIS) |
                      (8'(sign_q) << BIT_SIGN);

  // ----------------------------------------------------------------
  // Interrupt routing
  // ----------------------------------------------------------------
  // Event waits for the next sample strobe so the host sees it with data
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pending_q <= 1'b0;
      interrupt_line_a <= 1'b0;
      interrupt_line_b <= 1'b0;
    end else begin
      pending_q <= report | (pending_q & ~sample_ready);
      interrupt_line_a <= sample_ready & pending_q &
                          engine_control_q[BIT_ROUTE_LINE_A];
      interrupt_line_b <= sample_ready & pending_q &
                          ~engine_control_q[BIT_ROUTE_LINE_A];
    end
  end

endmodule

`default_nettype wire

/* tap_detection_engine_properties.sv */
/*
  Port checker for the tap detection engine.
  Bound to the engine top by the testbench; sees its ports only.
*/
`timescale 1ns/10ps
`default_nettype none

module tap_detection_engine_properties
  import tap_engine_pkg::*;
(
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       resetn,
  // Register port
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_rdata,
  // Strobe and interrupts
  input wire logic       sample_ready,
  input wire logic       interrupt_line_a,
  input wire logic       interrupt_line_b
);
  // ------------------------------------------
  // Properties
  // ------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  lines_apart_a: assert property (
    !(interrupt_line_a && interrupt_line_b))
    else $error("both interrupt lines high");
  a_synced_a: assert property (
    interrupt_line_a |-> $past(sample_ready))
    else $error("line a not after sample ready");
  b_synced_a: assert property (
    interrupt_line_b |-> $past(sample_ready))
    else $error("line b not after sample ready");
  a_pulse_a: assert property (
    interrupt_line_a |=> !interrupt_line_a)
    else $error("line a longer than one cycle");
  b_pulse_a: assert property (
    interrupt_line_b |=> !interrupt_line_b)
    else $error("line b longer than one cycle");
  rdata_hold_a: assert property (
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  unmapped_zero_a: assert property (
    reg_rd && reg_addr == 8'h7f |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  result_fields_a: assert property (
    reg_rd && reg_addr == ADDR_TAP_RESULT |=>
      reg_rdata[3:2] == 2'h0 && !reg_rdata[6] && reg_rdata[1:0] != 2'h3)
    else $error("tap result spare bits set");
  axis_count_a: assert property (
    reg_rd && reg_addr == ADDR_TAP_RESULT |=>
      (reg_rdata[1:0] == 2'h0) == (reg_rdata[5:4] == 2'h0))
    else $error("tap axis and count disagree");

endmodule
`default_nettype wire

/* tap_host_model.sv */
/*
  Host processor model: register writes, reads and tap setup.
  Assumes the engine takes strobes on the rising edge of ref_clk.
*/
`timescale 1ns/10ps
`default_nettype none

module tap_host_model
  import tap_engine_pkg::*;
#(
  // Nonzero rate code, assumed to be a fast one
  parameter logic [3:0] RATE_CODE = 4'h6
) (
  // Clock
  input  wire logic       ref_clk,
  // Register port
  output var  logic       reg_wr,
  output var  logic       reg_rd,
  output var  logic [7:0] reg_addr,
  output var  logic [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  // ------------------------------------------
  // Bus cycles
  // ------------------------------------------
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end

  // Idle bus shows inverted values, never stale ones
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge ref_clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
  endtask

  task automatic load(input logic [7:0] sel, input logic [47:0] b);
    for (int i = 0; i < 6; i++) begin
      wr(ADDR_PARAM_BYTE_0 + 8'(i), b[8*i +: 8]);
    end
    wr(ADDR_PARAM_SET_SELECT, sel);
    wr(ADDR_COMMAND, CMD_CONFIGURE_TAP);
  endtask

  task automatic cfg(input logic [7:0] order);
    wr(ADDR_SENSOR_ENABLE, 8'h00);
    load(SET_FIRST, {16'd60, 16'd10, order, 8'h02});
    load(SET_SECOND, {16'h0190, 16'h0320, 8'h00, 8'h00});
  endtask

  task automatic en(input logic [7:0] ctrl, input logic [7:0] acc);
    wr(ADDR_ACCEL_CONFIG, {4'h0, RATE_CODE});
    wr(ADDR_SENSOR_ENABLE, acc);
    wr(ADDR_ENGINE_CONTROL, ctrl);
  endtask

endmodule
`default_nettype wire

/* tap_detection_engine_tb.sv */
/*
  Self-checking testbench for the tap detection engine.
  Zero weights keep the average at zero, so linear value = sample.
*/
`timescale 1ns/10ps
`default_nettype none

bind tap_detection_engine tap_detection_engine_properties u_props (
  .ref_clk, .resetn, .reg_rd, .reg_addr, .reg_rdata,
  .sample_ready, .interrupt_line_a, .interrupt_line_b);

module tap_detection_engine_tb
  import tap_engine_pkg::*;
;
  // ------------------------------------------
  // Signals and instances
  // ------------------------------------------
  logic               ref_clk = 1'b0;
  logic               resetn = 1'b0;
  logic               sample_valid = 1'b0;
  logic               sample_ready = 1'b0;
  logic signed [15:0] accel_x = '0;
  logic signed [15:0] accel_y = '0;
  logic signed [15:0] accel_z = '0;
  logic               reg_wr, reg_rd, interrupt_line_a, interrupt_line_b;
  logic        [7:0]  reg_addr, reg_wdata, reg_rdata;
  int                 n_errors = 0;
  int                 n_compared = 0;
  int                 n_a = 0;
  int                 n_b = 0;

  always #12.5 ref_clk = ~ref_clk;

  tap_detection_engine dut (.ref_clk, .resetn, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .reg_rdata, .sample_valid, .accel_x,
    .accel_y, .accel_z, .sample_ready, .interrupt_line_a,
    .interrupt_line_b);
  tap_host_model u_host (.ref_clk, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .reg_rdata);

  always @(posedge ref_clk) begin
    if (interrupt_line_a === 1'b1)
      n_a++;
    if (interrupt_line_b === 1'b1)
      n_b++;
  end

  // ------------------------------------------
  // Helpers
  // ------------------------------------------
  task automatic results();
    if (n_errors == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic bad(input string s);
    n_errors++;
    $display("BAD %0t %s", $time, s);
  endtask

  task automatic chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    u_host.rd(a, d);
    n_compared++;
    if (d !== e)
      $display("BAD %0t read %h got %h exp %h", $time, a, d, e);
    if (d !== e)
      n_errors++;
  endtask

  // Compares then zeroes the interrupt counts
  task automatic cint(input int ea, input int eb);
    n_compared++;
    if (n_a != ea || n_b != eb)
      bad("interrupt count");
    n_a = 0;
    n_b = 0;
  endtask

  // Ready strobe trails the sample so a report lands before it
  task automatic smp(input logic signed [15:0] x, y, z);
    @(negedge ref_clk);
    sample_valid = 1'b1;
    accel_x = x;
    accel_y = y;
    accel_z = z;
    @(negedge ref_clk);
    sample_valid = 1'b0;
    repeat (2) @(negedge ref_clk);
    sample_ready = 1'b1;
    @(negedge ref_clk);
    sample_ready = 1'b0;
  endtask

  task automatic hit(input logic signed [15:0] x, y, z, input int n);
    smp(x, y, z);
    repeat (n) smp(16'sd0, 16'sd0, 16'sd0);
  endtask

  // ------------------------------------------
  // Scenarios
  // ------------------------------------------
  task automatic t_single();
    u_host.cfg(8'h00);
    u_host.en(8'h01, 8'h01);
    cint(0, 0);
    hit(16'sd1024, 16'sd0, 16'sd0, 80);
    cint(0, 1);
    chk(ADDR_TAP_RESULT, {2'b00, AXIS_X, 2'b00, COUNT_SINGLE});
    chk(ADDR_INTERRUPT_STATUS, 8'h02);
    chk(ADDR_EVENT_STATUS, 8'h02);
    chk(ADDR_EVENT_STATUS, 8'h00);
  endtask

  task automatic t_double();
    u_host.en(8'h41, 8'h01);
    cint(0, 0);
    hit(16'sd0, -16'sd1024, 16'sd0, 25);
    hit(16'sd0, -16'sd1024, 16'sd0, 80);
    cint(1, 0);
    chk(ADDR_TAP_RESULT, {2'b10, AXIS_Y, 2'b00, COUNT_DOUBLE});
    chk(ADDR_EVENT_STATUS, 8'h02);
  endtask

  task automatic t_undef();
    hit(16'sd0, 16'sd0, 16'sd1024, 5);
    hit(16'sd0, 16'sd0, 16'sd1024, 80);
    cint(0, 0);
    chk(ADDR_EVENT_STATUS, 8'h00);
  endtask

  // Weight of one: each average follows the last value
  task automatic t_weights();
    u_host.cfg(8'h00);
    u_host.load(SET_SECOND, {16'h0190, 16'h0320, 8'h00, 8'h80});
    u_host.en(8'h41, 8'h01);
    smp(16'sd800, 16'sd0, 16'sd0);
    repeat (20) smp(16'sd1600, 16'sd0, 16'sd0);
    hit(16'sd800, 16'sd0, 16'sd0, 80);
    cint(0, 0);
    u_host.wr(ADDR_SENSOR_ENABLE, 8'h00);
    u_host.load(SET_SECOND, {16'h0190, 16'h0320, 8'h80, 8'h80});
    u_host.en(8'h41, 8'h01);
    smp(16'sd1024, 16'sd0, 16'sd0);
    smp(16'sd0, 16'sd0, 16'sd0);
    hit(16'sd1024, 16'sd0, 16'sd0, 80);
    cint(0, 0);
    hit(16'sd1024, 16'sd0, 16'sd0, 80);
    cint(1, 0);
    chk(ADDR_TAP_RESULT, {2'b00, AXIS_X, 2'b00, COUNT_SINGLE});
  endtask

  task automatic t_ties();
    logic [1:0] ax [9] = '{AXIS_X, AXIS_X, AXIS_Y, AXIS_Y, AXIS_Z,
                           AXIS_Z, AXIS_X, AXIS_X, AXIS_Z};
    logic [7:0] code;
    for (int i = 0; i < 9; i++) begin
      code = (i == 8) ? 8'hfd : 8'(i);
      u_host.cfg(code);
      u_host.en(8'h01, 8'h01);
      hit(16'sd591, 16'sd591, 16'sd591, 80);
      cint(0, 1);
      chk(ADDR_TAP_RESULT, {2'b00, ax[i], 2'b00, COUNT_SINGLE});
    end
  endtask

  task automatic t_enable();
    u_host.en(8'h40, 8'h01);
    cint(0, 0);
    hit(16'sd1024, 16'sd0, 16'sd0, 80);
    cint(0, 0);
    u_host.en(8'h41, 8'h00);
    hit(16'sd1024, 16'sd0, 16'sd0, 80);
    cint(0, 0);
    u_host.en(8'h41, 8'h01);
    hit(16'sd905, 16'sd0, 16'sd0, 80);
    cint(0, 0);
    hit(16'sd906, 16'sd0, 16'sd0, 80);
    cint(1, 0);
    u_host.wr(ADDR_TAP_RESULT, 8'hff);
    chk(ADDR_TAP_RESULT, {2'b00, AXIS_X, 2'b00, COUNT_SINGLE});
    chk(8'h7f, 8'h00);
  endtask

  initial begin
    repeat (10) @(posedge ref_clk);
    @(negedge ref_clk);
    resetn = 1'b1;
    t_single();
    t_double();
    t_undef();
    t_weights();
    t_ties();
    t_enable();
    results();
  end

  // Run needs about 9000 cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    bad("watchdog");
    results();
  end

endmodule
`default_nettype wire
